// ### bgr_run_ctrl.sv
// The APB register port and the address map were decided locally.
`timescale 1ns/100ps
module bgr_run_ctrl (
  input  wire logic                        pclk,                    // 20 MHz system clock
  input  wire logic                        presetn,                 // Async reset, active low
  input  wire logic                        psel,                    // APB select
  input  wire logic                        penable,                 // APB enable
  input  wire logic                        pwrite,                  // APB write
  input  wire logic [7:0]                  paddr,                   // APB byte address
  input  wire logic [31:0]                 pwdata,                  // APB write data
  output logic      [31:0]                 prdata,                  // APB read data
  output logic                             pready,                  // APB ready
  output logic                             pslverr,                 // APB error
  input  wire logic [7:0]                  battery_voltage,         // Volts x10
  input  wire logic [7:0]                  soc_percent,             // State of charge %
  input  wire logic [4:0]                  hour_of_day,             // 0..23
  input  wire logic                        minute_tick,             // One pulse per minute
  input  wire logic                        day_tick,                // One pulse at midnight
  input  wire logic [bgr_pkg::CUR_W-1:0]   internal_charge_current, // Solar input current
  input  wire logic                        ext_valid,               // External report pulse
  input  wire logic [1:0]                  ext_kind,                // Device kind
  input  wire logic [3:0]                  ext_num,                 // Device number
  input  wire logic [bgr_pkg::CUR_W-1:0]   ext_current,             // Reported current
  output logic      [bgr_pkg::SUM_W-1:0]   total_charge_current,    // Internal plus externals
  output logic                             run_contact,             // Closed while run wanted
  output logic                             run_request_indicator    // Visible run flag
);
  import bgr_pkg::*;

  logic [2:0]       backup_mode_select;
  logic [2:0]       program_select;
  logic [7:0]       start_threshold;
  logic [7:0]       stop_threshold;
  logic [3:0]       changeover_delay;
  logic [5:0]       exercise_interval_days;
  logic [5:0]       exercise_run_hours;
  logic [5:0]       days_since_exercise;
  logic [7:0]       exercise_elapsed_time;
  logic [IDX_W-1:0] dev_sel;
  logic [(1<<IDX_W)-1:0] present;
  logic             auto_run;
  logic             exercising;
  logic [SUM_W-1:0] ext_sum;

  logic             wr_en;
  logic             rd_setup;
  logic             addr_ok;
  logic             manual_run_toggle;
  logic [2:0]       eff_mode;
  logic             quiet;
  logic             on_volt;
  logic             on_soc;
  logic             off_volt;
  logic             off_soc;
  logic             on_done;
  logic             off_done;
  logic             toggle_ok;
  logic [7:0]       run_minutes;
  logic             run_expired;
  logic             ex_start;
  logic             run_request;

  // APB slave: zero wait, read data captured in the setup cycle
  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;

  always_comb begin
    unique case (paddr)
      OFS_CTRL, OFS_START, OFS_STOP, OFS_DELAY, OFS_EX_DAYS, OFS_RUN_LEN,
      OFS_DAY_CNT, OFS_ELAPSED, OFS_STATUS, OFS_TOTAL, OFS_DEV_SEL,
      OFS_DEV_INFO: addr_ok = 1'b1;
      default:      addr_ok = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !addr_ok;
  assign manual_run_toggle = wr_en && (paddr == OFS_CTRL) && pwdata[CTRL_TOGGLE_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      backup_mode_select     <= RST_MODE;
      program_select         <= RST_PROG;
      start_threshold        <= RST_START;
      stop_threshold         <= RST_STOP;
      changeover_delay       <= RST_DELAY;
      exercise_interval_days <= RST_EX_DAYS;
      exercise_run_hours     <= RST_RUN;
      dev_sel                <= '0;
    end else if (wr_en) begin
      unique case (paddr)
        OFS_CTRL: begin
          // Codes 7 are refused so the selector stays in 0..6
          if (pwdata[2:0] <= MODE_NQ_SOC) begin
            backup_mode_select <= pwdata[2:0];
          end
          program_select <= pwdata[CTRL_PROG_LSB +: 3];
        end
        OFS_START:   start_threshold <= pwdata[7:0];
        OFS_STOP:    stop_threshold  <= pwdata[7:0];
        OFS_DELAY: begin
          changeover_delay <= (pwdata[3:0] < DELAY_MIN) ? DELAY_MIN : pwdata[3:0];
        end
        OFS_EX_DAYS: exercise_interval_days <= pwdata[5:0];
        OFS_RUN_LEN: begin
          exercise_run_hours <= (pwdata[5:0] > RUN_MAX) ? RUN_MAX : pwdata[5:0];
        end
        OFS_DEV_SEL: dev_sel <= pwdata[IDX_W-1:0];
        default: ;
      endcase
    end
  end

  function automatic logic [7:0] dev_label(input logic [3:0] num);
    logic [7:0] c;
    c = CHAR_ZERO + {4'h0, num};
    if (num == NUM_TEN) begin
      c = CHAR_TEN;
    end else if (num == NUM_ELEVEN) begin
      c = CHAR_ELEVEN;
    end else if (num == MAX_OTHER) begin
      c = CHAR_TWELVE;
    end
    return c;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (paddr)
        OFS_CTRL:     prdata <= {25'h0, program_select, 1'b0, backup_mode_select};
        OFS_START:    prdata <= {24'h0, start_threshold};
        OFS_STOP:     prdata <= {24'h0, stop_threshold};
        OFS_DELAY:    prdata <= {28'h0, changeover_delay};
        OFS_EX_DAYS:  prdata <= {26'h0, exercise_interval_days};
        OFS_RUN_LEN:  prdata <= {26'h0, exercise_run_hours};
        OFS_DAY_CNT:  prdata <= {26'h0, days_since_exercise};
        OFS_ELAPSED:  prdata <= {24'h0, exercise_elapsed_time};
        OFS_STATUS:   prdata <= {25'h0, auto_run, exercising, quiet, run_request, eff_mode};
        OFS_TOTAL:    prdata <= {{(32-SUM_W){1'b0}}, total_charge_current};
        OFS_DEV_SEL:  prdata <= {{(32-IDX_W){1'b0}}, dev_sel};
        OFS_DEV_INFO: prdata <= {17'h0, present[dev_sel], dev_sel, dev_label(dev_sel[3:0])};
        default:      prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Mode decode
  assign eff_mode = (program_select < PROG_USER) ? MODE_VOLT : backup_mode_select;
  assign quiet    = (eff_mode < MODE_MANUAL) &&
                    ((hour_of_day >= QUIET_START_HR) || (hour_of_day < QUIET_END_HR));
  assign on_volt  = (eff_mode == MODE_VOLT) || (eff_mode == MODE_NQ_VOLT);
  assign on_soc   = (eff_mode == MODE_SOC_V) || (eff_mode == MODE_SOC) ||
                    (eff_mode == MODE_NQ_SOC_V) || (eff_mode == MODE_NQ_SOC);
  assign off_soc  = (eff_mode == MODE_SOC) || (eff_mode == MODE_NQ_SOC);
  assign off_volt = !off_soc && (eff_mode != MODE_MANUAL);

  bgr_delay_timer u_on_timer (
    .pclk        (pclk),
    .presetn     (presetn),
    .cond        (on_volt && !auto_run && (battery_voltage <= start_threshold)),
    .minute_tick (minute_tick),
    .delay_min   (changeover_delay),
    .done        (on_done)
  );

  bgr_delay_timer u_off_timer (
    .pclk        (pclk),
    .presetn     (presetn),
    .cond        (off_volt && auto_run && (battery_voltage >= stop_threshold)),
    .minute_tick (minute_tick),
    .delay_min   (changeover_delay),
    .done        (off_done)
  );

  assign toggle_ok   = manual_run_toggle && !exercising;
  assign run_minutes = {2'h0, exercise_run_hours} * MIN_PER_TENTH;
  assign run_expired = exercise_elapsed_time >= run_minutes;

  // Auto and manual run state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_run <= 1'b0;
    end else if (toggle_ok) begin
      auto_run <= !auto_run;
    end else if (eff_mode == MODE_MANUAL) begin
      if (auto_run && run_expired) begin
        auto_run <= 1'b0;
      end
    end else if (!auto_run) begin
      if ((on_volt && on_done) || (on_soc && (soc_percent <= start_threshold))) begin
        auto_run <= 1'b1;
      end
    end else if ((off_volt && off_done) || (off_soc && (soc_percent >= stop_threshold))) begin
      auto_run <= 1'b0;
    end
  end

  // Exercise scheduling
  assign ex_start = !exercising && (eff_mode != MODE_MANUAL) &&
                    (days_since_exercise >= exercise_interval_days);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exercising <= 1'b0;
    end else if (ex_start) begin
      exercising <= 1'b1;
    end else if (exercising && run_expired) begin
      exercising <= 1'b0;
    end
  end

  // Software writes win so the counters can be preset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      days_since_exercise <= '0;
    end else if (wr_en && paddr == OFS_DAY_CNT) begin
      days_since_exercise <= pwdata[5:0];
    end else if (ex_start) begin
      days_since_exercise <= '0;
    end else if (day_tick && days_since_exercise != DAYS_MAX) begin
      days_since_exercise <= days_since_exercise + 6'h01;
    end
  end

  // Shared by exercise runs and timed manual runs; an exercise cannot start in manual mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exercise_elapsed_time <= '0;
    end else if (wr_en && paddr == OFS_ELAPSED) begin
      exercise_elapsed_time <= pwdata[7:0];
    end else if (ex_start || (toggle_ok && !auto_run)) begin
      // Any honoured start toggle clears the count, so a mode change in the same write is safe
      exercise_elapsed_time <= '0;
    end else if (minute_tick && !run_expired &&
                 (exercising || (auto_run && eff_mode == MODE_MANUAL))) begin
      exercise_elapsed_time <= exercise_elapsed_time + 8'h01;
    end
  end

  assign run_request = (auto_run || exercising) && !quiet;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_contact           <= 1'b0;
      run_request_indicator <= 1'b0;
    end else begin
      run_contact           <= run_request;
      run_request_indicator <= run_request;
    end
  end

  // External current collection: a report reads the old value, then replaces it
  bgr_mem_if mem_port ();
  logic [IDX_W-1:0] s1_idx;
  logic [IDX_W-1:0] s2_idx;
  logic [CUR_W-1:0] s1_cur;
  logic [CUR_W-1:0] s2_cur;
  logic             s1_valid;
  logic             s2_valid;
  logic             ext_ok;
  logic [CUR_W-1:0] old_cur;

  bgr_cur_mem u_mem (
    .pclk (pclk),
    .port (mem_port)
  );

  assign ext_ok = ext_valid && (ext_num != 4'h0) && (ext_kind != 2'h3) &&
                  (ext_num <= ((ext_kind == KIND_SHUNT) ? MAX_SHUNT : MAX_OTHER));
  assign mem_port.raddr = {ext_kind, ext_num};
  assign mem_port.we    = s1_valid;
  assign mem_port.waddr = s1_idx;
  assign mem_port.wdata = s1_cur;
  // Back-to-back reports on one slot would read a stale word
  assign old_cur = !present[s1_idx] ? '0 :
                   (s2_valid && s2_idx == s1_idx) ? s2_cur : mem_port.rdata;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_valid <= 1'b0;
      s2_valid <= 1'b0;
      s1_idx   <= '0;
      s2_idx   <= '0;
      s1_cur   <= '0;
      s2_cur   <= '0;
    end else begin
      s1_valid <= ext_ok;
      s1_idx   <= {ext_kind, ext_num};
      s1_cur   <= ext_current;
      s2_valid <= s1_valid;
      s2_idx   <= s1_idx;
      s2_cur   <= s1_cur;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      present <= '0;
      ext_sum <= '0;
    end else if (s1_valid) begin
      present[s1_idx] <= 1'b1;
      ext_sum <= ext_sum - {{(SUM_W-CUR_W){1'b0}}, old_cur} +
                 {{(SUM_W-CUR_W){1'b0}}, s1_cur};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      total_charge_current <= '0;
    end else begin
      total_charge_current <= ext_sum + {{(SUM_W-CUR_W){1'b0}}, internal_charge_current};
    end
  end

  sequence seq_toggle_free;
    manual_run_toggle && !exercising && (eff_mode != MODE_MANUAL);
  endsequence

  sequence seq_toggle_blocked;
    manual_run_toggle && exercising && !auto_run && !on_done &&
    !(on_soc && (soc_percent <= start_threshold));
  endsequence

  a_quiet_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    quiet |=> !run_contact) else $error("run contact closed in quiet window");
  a_no_quiet_run: assert property (@(posedge pclk) disable iff (!presetn)
    (eff_mode >= MODE_NQ_VOLT && (auto_run || exercising)) |=> run_contact)
    else $error("no-quiet mode failed to run");
  a_prog_forces: assert property (@(posedge pclk) disable iff (!presetn)
    program_select < PROG_USER |-> eff_mode == MODE_VOLT)
    else $error("generic program did not force mode zero");
  a_volt_start: assert property (@(posedge pclk) disable iff (!presetn)
    (on_volt && !auto_run && on_done && !manual_run_toggle) |=> auto_run)
    else $error("voltage start missed");
  a_soc_start: assert property (@(posedge pclk) disable iff (!presetn)
    (on_soc && !auto_run && soc_percent <= start_threshold && !manual_run_toggle) |=> auto_run)
    else $error("charge-level start missed");
  a_soc_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (off_soc && auto_run && soc_percent >= stop_threshold && !manual_run_toggle) |=> !auto_run)
    else $error("charge-level stop missed");
  a_toggle_inverts: assert property (@(posedge pclk) disable iff (!presetn)
    seq_toggle_free |=> auto_run != $past(auto_run))
    else $error("toggle did not invert run");
  a_toggle_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    seq_toggle_blocked |=> !auto_run) else $error("toggle acted during exercise");
  a_manual_no_ex: assert property (@(posedge pclk) disable iff (!presetn)
    eff_mode == MODE_MANUAL |=> !$rose(exercising)) else $error("exercise in manual mode");
  a_exercise_len: assert property (@(posedge pclk) disable iff (!presetn)
    (exercising && run_expired && !ex_start) |=> !exercising)
    else $error("exercise overran its length");
endmodule

// ### bgr_pkg.sv
package bgr_pkg;
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_START    = 8'h04;
  localparam logic [7:0] OFS_STOP     = 8'h08;
  localparam logic [7:0] OFS_DELAY    = 8'h0C;
  localparam logic [7:0] OFS_EX_DAYS  = 8'h10;
  localparam logic [7:0] OFS_RUN_LEN  = 8'h14;
  localparam logic [7:0] OFS_DAY_CNT  = 8'h18;
  localparam logic [7:0] OFS_ELAPSED  = 8'h1C;
  localparam logic [7:0] OFS_STATUS   = 8'h20;
  localparam logic [7:0] OFS_TOTAL    = 8'h24;
  localparam logic [7:0] OFS_DEV_SEL  = 8'h28;
  localparam logic [7:0] OFS_DEV_INFO = 8'h2C;

  localparam int CTRL_PROG_LSB   = 4;
  localparam int CTRL_TOGGLE_BIT = 8;

  localparam logic [2:0] RST_MODE    = 3'h0;
  localparam logic [2:0] RST_PROG    = 3'h4;
  localparam logic [7:0] RST_START   = 8'h78;
  localparam logic [7:0] RST_STOP    = 8'h8C;
  localparam logic [3:0] RST_DELAY   = 4'hA;
  localparam logic [3:0] DELAY_MIN   = 4'h1;
  localparam logic [5:0] RST_EX_DAYS = 6'h0E;
  localparam logic [5:0] RST_RUN     = 6'h0A;
  localparam logic [5:0] RUN_MAX     = 6'h28;
  localparam logic [5:0] DAYS_MAX    = 6'h3F;
  localparam logic [7:0] MIN_PER_TENTH = 8'h06;

  localparam logic [4:0] QUIET_START_HR = 5'h15;
  localparam logic [4:0] QUIET_END_HR   = 5'h09;

  localparam logic [2:0] MODE_VOLT     = 3'h0;
  localparam logic [2:0] MODE_SOC_V    = 3'h1;
  localparam logic [2:0] MODE_SOC      = 3'h2;
  localparam logic [2:0] MODE_MANUAL   = 3'h3;
  localparam logic [2:0] MODE_NQ_VOLT  = 3'h4;
  localparam logic [2:0] MODE_NQ_SOC_V = 3'h5;
  localparam logic [2:0] MODE_NQ_SOC   = 3'h6;
  localparam logic [2:0] PROG_USER     = 3'h4;

  localparam logic [1:0] KIND_SHUNT   = 2'h0;
  localparam logic [1:0] KIND_TRACKER = 2'h1;
  localparam logic [1:0] KIND_SWITCH  = 2'h2;
  localparam logic [3:0] MAX_SHUNT    = 4'h4;
  localparam logic [3:0] MAX_OTHER    = 4'hC;
  localparam logic [3:0] NUM_TEN      = 4'hA;
  localparam logic [3:0] NUM_ELEVEN   = 4'hB;
  localparam logic [7:0] CHAR_ZERO    = 8'h30;
  localparam logic [7:0] CHAR_TEN     = 8'h41;
  localparam logic [7:0] CHAR_ELEVEN  = 8'h62;
  localparam logic [7:0] CHAR_TWELVE  = 8'h43;

  localparam int CUR_W = 16;
  localparam int SUM_W = 20;
  localparam int IDX_W = 6;
endpackage

// ### bgr_mem_if.sv
`timescale 1ns/100ps
interface bgr_mem_if;
  import bgr_pkg::*;
  logic                 we;
  logic [IDX_W-1:0]     waddr;
  logic [CUR_W-1:0]     wdata;
  logic [IDX_W-1:0]     raddr;
  logic [CUR_W-1:0]     rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ### bgr_cur_mem.sv
`timescale 1ns/100ps
module bgr_cur_mem (
  input  wire logic pclk,     // System clock
  bgr_mem_if.mem    port      // Current store port
);
  import bgr_pkg::*;
  logic [CUR_W-1:0] store [0:(1<<IDX_W)-1];

  // No reset: a slot is only read after discovery has written it
  always_ff @(posedge pclk) begin
    if (port.we) begin
      store[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge pclk) begin
    port.rdata <= store[port.raddr];
  end
endmodule

// ### bgr_delay_timer.sv
`timescale 1ns/100ps
module bgr_delay_timer (
  input  wire logic       pclk,        // System clock
  input  wire logic       presetn,     // Async reset, active low
  input  wire logic       cond,        // Qualifying condition
  input  wire logic       minute_tick, // One pulse per minute
  input  wire logic [3:0] delay_min,   // Delay in minutes
  output logic            done         // Condition held for the delay
);
  import bgr_pkg::*;
  logic [3:0] count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 4'h0;
    end else if (!cond) begin
      count <= 4'h0;
    end else if (minute_tick && count < delay_min) begin
      count <= count + 4'h1;
    end
  end

  assign done = cond && (count >= delay_min);

  a_timer_restart: assert property (@(posedge pclk) disable iff (!presetn)
    !cond |=> count == 4'h0) else $error("delay timer kept count after lapse");
  a_timer_no_early: assert property (@(posedge pclk) disable iff (!presetn)
    (!cond ##1 cond) |-> !done) else $error("delay timer done without waiting");
endmodule

// ### bgr_gen_model.sv
`timescale 1ns/100ps
module bgr_gen_model #(
  parameter int START_CYC = 4
) (
  input  wire logic pclk,        // System clock
  input  wire logic presetn,     // Async reset, active low
  input  wire logic run_contact, // Contact closure from the controller
  output logic      running      // Engine up and running
);
  int cnt;

  // Own crank sequence; the controller only gives a level, never a start pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt     <= 0;
      running <= 1'b0;
    end else if (!run_contact) begin
      cnt     <= 0;
      running <= 1'b0;
    end else if (cnt == START_CYC) begin
      running <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ### backup_generator_run_control_test.sv
`timescale 1ns/100ps
module backup_generator_run_control_test;
  import bgr_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]        paddr, battery_voltage, soc_percent;
  logic [31:0]       pwdata, prdata, rdat;
  logic [4:0]        hour_of_day;
  logic              minute_tick, day_tick, ext_valid, rerr, running;
  logic [1:0]        ext_kind;
  logic [3:0]        ext_num;
  logic [CUR_W-1:0]  internal_charge_current, ext_current;
  logic [SUM_W-1:0]  total_charge_current;
  logic              run_contact, run_request_indicator;
  int                error_cnt, checks, cyc;
  logic [5:0]        sel_t [4] = '{6'h1A, 6'h1B, 6'h2C, 6'h04};
  logic [7:0]        chr_t [4] = '{CHAR_TEN, CHAR_ELEVEN, CHAR_TWELVE, 8'h34};

  bgr_run_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .battery_voltage(battery_voltage), .soc_percent(soc_percent),
    .hour_of_day(hour_of_day), .minute_tick(minute_tick), .day_tick(day_tick),
    .internal_charge_current(internal_charge_current), .ext_valid(ext_valid),
    .ext_kind(ext_kind), .ext_num(ext_num), .ext_current(ext_current),
    .total_charge_current(total_charge_current), .run_contact(run_contact),
    .run_request_indicator(run_request_indicator));
  bgr_gen_model gen (.pclk(pclk), .presetn(presetn), .run_contact(run_contact),
    .running(running));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Generous ceiling: the whole run needs well under two thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends when pready is seen high; the bench timeout covers a missing pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rdat & m, e);
  endtask

  task automatic ctrl(input logic [2:0] m, input logic [2:0] p, input logic t);
    apb(1'b1, OFS_CTRL, {23'h0, t, 1'b0, p, 1'b0, m});
  endtask

  task automatic pulse(input logic day, input int n);
    repeat (n) begin
      @(posedge pclk);
      if (day) day_tick <= 1'b1;
      else minute_tick <= 1'b1;
      @(posedge pclk);
      day_tick <= 1'b0;
      minute_tick <= 1'b0;
    end
  endtask

  task automatic run_is(input logic e);
    repeat (3) @(posedge pclk);
    chk("run_contact", run_contact, e);
    chk("run_indicator", run_request_indicator, e);
  endtask

  task automatic ext(input logic [1:0] k, input logic [3:0] n, input logic [15:0] c);
    @(posedge pclk);
    ext_valid <= 1'b1;
    ext_kind <= k;
    ext_num <= n;
    ext_current <= c;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, minute_tick, day_tick, ext_valid} = '0;
    {paddr, pwdata, ext_kind, ext_num, ext_current} = '0;
    battery_voltage = 8'h80;
    soc_percent = 8'h32;
    hour_of_day = 5'h0C;
    internal_charge_current = 16'h0064;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_START, 32'hFF, 32'h78, "start_thr");
    rd(OFS_STOP, 32'hFF, 32'h8C, "stop_thr");
    rd(OFS_DELAY, 32'hF, 32'hA, "delay");
    rd(OFS_EX_DAYS, 32'h3F, 32'hE, "ex_days");
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped_err", rerr, 32'h1);
    ctrl(3'h4, 3'h4, 1'b0);
    ctrl(3'h7, 3'h4, 1'b0);
    rd(OFS_STATUS, 32'h7, 32'h4, "mode_kept");
    ctrl(3'h5, 3'h2, 1'b0);
    rd(OFS_STATUS, 32'h7, 32'h0, "forced_mode");
    ctrl(3'h0, 3'h4, 1'b0);
    $display("test registers done");
    apb(1'b1, OFS_DELAY, 32'h2);
    battery_voltage <= 8'h78;
    pulse(1'b0, 1);
    battery_voltage <= 8'h80;
    run_is(1'b0);
    battery_voltage <= 8'h78;
    pulse(1'b0, 1);
    run_is(1'b0);
    pulse(1'b0, 1);
    run_is(1'b1);
    repeat (8) @(posedge pclk);
    chk("gen_running", running, 32'h1);
    battery_voltage <= 8'h8C;
    pulse(1'b0, 1);
    run_is(1'b1);
    pulse(1'b0, 1);
    run_is(1'b0);
    battery_voltage <= 8'h80;
    $display("test voltage done");
    hour_of_day <= 5'h16;
    ctrl(3'h0, 3'h4, 1'b1);
    run_is(1'b0);
    ctrl(3'h4, 3'h4, 1'b0);
    run_is(1'b1);
    ctrl(3'h4, 3'h4, 1'b1);
    run_is(1'b0);
    hour_of_day <= 5'h0C;
    $display("test quiet done");
    apb(1'b1, OFS_START, 32'h1E);
    apb(1'b1, OFS_STOP, 32'h6E);
    ctrl(3'h2, 3'h4, 1'b0);
    soc_percent <= 8'h1E;
    run_is(1'b1);
    soc_percent <= 8'h64;
    run_is(1'b1);
    soc_percent <= 8'h6E;
    run_is(1'b0);
    soc_percent <= 8'h32;
    $display("test soc done");
    apb(1'b1, OFS_RUN_LEN, 32'h1);
    ctrl(3'h3, 3'h4, 1'b1);
    pulse(1'b0, 5);
    run_is(1'b1);
    pulse(1'b0, 1);
    run_is(1'b0);
    apb(1'b1, OFS_EX_DAYS, 32'h2);
    apb(1'b1, OFS_DAY_CNT, 32'h0);
    pulse(1'b1, 3);
    run_is(1'b0);
    apb(1'b1, OFS_DAY_CNT, 32'h5);
    rd(OFS_DAY_CNT, 32'h3F, 32'h5, "day_cnt");
    apb(1'b1, OFS_DAY_CNT, 32'h0);
    ctrl(3'h4, 3'h4, 1'b0);
    pulse(1'b1, 1);
    run_is(1'b0);
    pulse(1'b1, 1);
    run_is(1'b1);
    rd(OFS_STATUS, 32'h20, 32'h20, "exercising");
    ctrl(3'h4, 3'h4, 1'b1);
    run_is(1'b1);
    pulse(1'b0, 5);
    rd(OFS_ELAPSED, 32'hFF, 32'h5, "elapsed");
    pulse(1'b0, 1);
    run_is(1'b0);
    $display("test manual and exercise done");
    ext(2'h1, 4'hA, 16'h5);
    ext(2'h2, 4'hC, 16'h3);
    ext(2'h0, 4'h4, 16'h7);
    ext(2'h0, 4'h5, 16'h32);
    ext(2'h3, 4'h1, 16'h32);
    ext(2'h1, 4'hB, 16'h0);
    ext(2'h1, 4'hA, 16'h6);
    @(posedge pclk);
    ext_valid <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("total_current", total_charge_current, 32'h74);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFS_DEV_SEL, {26'h0, sel_t[i]});
      rd(OFS_DEV_INFO, 32'h40FF, {24'h0, chr_t[i]} | 32'h4000, "dev_info");
    end
    $display("test current done");
    complete_run();
  end
endmodule
